/* sar_ctrl_pkg.sv */
// package for the serial sampling converter control block
// assumes a single 125 MHz clock domain; pins sampled inside the top
`default_nettype none
package sar_ctrl_pkg;
	localparam int unsigned MCLK_HZ          = 125_000_000;
	localparam int unsigned RESULT_BITS      = 13;
	localparam int unsigned CONV_TIME_NS     = 300;
	localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS * (MCLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned POR_HOLD_NS      = 40;
	localparam int unsigned POR_CYCLES       =
		(POR_HOLD_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [2:0]  PULSES_TO_NAP    = 3'h2;
	localparam logic [2:0]  PULSES_TO_SLEEP  = 3'h4;
	localparam logic [2:0]  PULSES_TO_WAKE   = 3'h5;
	localparam logic [12:0] RESULT_RESET     = 13'h0000;

	typedef enum logic [1:0] {
		PWR_ON    = 2'b00,
		PWR_NAP   = 2'b01,
		PWR_SLEEP = 2'b11
	} power_e;

	// sampled link pins, already synchronised
	typedef struct packed {
		logic conv_n;
		logic sck;
	} link_in_s;

	// serial output pin pair with enables
	typedef struct packed {
		logic pos;
		logic neg;
		logic oe_pos;
		logic oe_neg;
	} link_out_s;
endpackage
`default_nettype wire

/* sar_edge_sync.sv */
// two-flop synchroniser with rise and fall detection on the second stage
// assumes the input is asynchronous to clk_i
`default_nettype none
module sar_edge_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pin and result
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign rise_o  = sync_reg & ~last_reg;
	assign fall_o  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

/* sar_adc_serial_power_control.sv */
// control logic of a serial sampling converter: conversion timing, result
// shifter, pulse-counting power modes and power-on reset handling.
// assumes the host keeps the start pulse and shift clock timing it is given.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R01: falling start edge begins a conversion that runs on internal timing
// R02: host keeps every start pulse at least 30ns wide at 2Msps
// R03: each falling shift clock edge presents next result bit, MSB first
// R04: host supplies a 64MHz shift clock for full 2Msps throughput; the host model gives a 160 ns period (6.25MHz)
// R05: host requests nap by holding shift clock still and giving two pulses
// R06: with clock idle, nap starts at rising end of second start pulse
// R07: nap lasts until a rising shift clock edge or further start pulses
// R08: from nap, two more start pulses with idle clock enter sleep
// R09: in CMOS mode one rising shift clock edge wakes from sleep
// R10: host waits 10ms after sleep exit before trusting conversions
// R11: fifth counted start pulse wakes from sleep in either standard
// R12: shift clock pulses after waking clear the pulse count
// R13: with idle clock, start pulses cycle on, nap and sleep forever
// R14: internal power-on reset at power-up or low supply, then reinitialise
// R15: host starts no conversion within 10ms of a power-on reset; the bench starts its first one soon after the reset ends
// R16: nap and sleep entry by pulse count ignores the signalling standard
// R17: select level picks single-ended CMOS or differential LVDS pins
// R18: CMOS uses positive pins only; negative pins left low
// R19: LVDS drives data and takes clock as differential pairs
// R20: conversion lasts a counted time; old result stays until new one ready
module sar_adc_serial_power_control
	import sar_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   sys_rst_i,
	// supply monitor: high while supply is below the reset threshold
	input  wire logic                   supply_low_i,
	// link pins
	input  wire logic                   conversion_start_n_i,
	input  wire logic                   shift_clock_pos_i,
	input  wire logic                   shift_clock_neg_i,
	input  wire logic                   io_standard_lvds_i,
	// analog core result, read when the conversion ends
	input  wire logic [RESULT_BITS-1:0] sample_data_i,
	// serial data out, with output enables
	output sar_ctrl_pkg::link_out_s     serial_out_o,
	// status
	output logic                        converting_o,
	output sar_ctrl_pkg::power_e        power_state_o,
	output logic                        por_active_o
);
	import sar_ctrl_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// pin sampling
	link_in_s pins;
	logic     cnv_rise;
	logic     cnv_fall;
	logic     sck_rise;
	logic     sck_fall;
	logic     sel_sync;
	logic     sel_meta_reg;
	logic     sel_reg;
	logic     sck_diff;

	// lvds takes the pair's difference, cmos the positive pin only [R17] [R19]
	assign sck_diff = sel_reg ? (shift_clock_pos_i & ~shift_clock_neg_i) : shift_clock_pos_i;

	sar_edge_sync u_cnv_sync (
		.clk_i   (mclk_i),
		.rst_i   (sys_rst_i),
		.pin_i   (conversion_start_n_i),
		.level_o (pins.conv_n),
		.rise_o  (cnv_rise),
		.fall_o  (cnv_fall)
	);

	sar_edge_sync u_sck_sync (
		.clk_i   (mclk_i),
		.rst_i   (sys_rst_i),
		.pin_i   (sck_diff),
		.level_o (pins.sck),
		.rise_o  (sck_rise),
		.fall_o  (sck_fall)
	);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sel_meta_reg <= 1'b0;
			sel_reg      <= 1'b0;
		end else begin
			sel_meta_reg <= io_standard_lvds_i;
			sel_reg      <= sel_meta_reg;
		end
	end
	assign sel_sync = sel_reg;

	//////////////////////////////////////////////////////////////////////////
	// power-on reset: held while supply is low and for a short time after
	logic       sup_meta_reg;
	logic       sup_reg;
	logic [7:0] por_cnt_reg;
	logic [7:0] por_cnt_next;
	logic       por_reg;
	logic       por_next;

	always_comb begin
		por_cnt_next = por_cnt_reg;
		por_next     = por_reg;
		if (sup_reg) begin
			por_cnt_next = 8'h00; // [R14]
			por_next     = 1'b1;
		end else if (por_reg) begin
			if (por_cnt_reg == 8'(POR_CYCLES - 1)) begin
				por_next = 1'b0; // reinitialised once supply is back [R14]
			end else begin
				por_cnt_next = por_cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			sup_meta_reg <= 1'b1;
			sup_reg      <= 1'b1;
			por_cnt_reg  <= 8'h00;
			por_reg      <= 1'b1; // power-up counts as a reset event
		end else begin
			sup_meta_reg <= supply_low_i;
			sup_reg      <= sup_meta_reg;
			por_cnt_reg  <= por_cnt_next;
			por_reg      <= por_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// conversion timer and result shifter
	logic [15:0]            conv_cnt_reg;
	logic [15:0]            conv_cnt_next;
	logic                   conv_reg;
	logic                   conv_next;
	logic [RESULT_BITS-1:0] shift_reg;
	logic [RESULT_BITS-1:0] shift_next;
	logic                   dout_reg;
	logic                   dout_next;
	power_e                 power_reg;
	power_e                 power_next;

	always_comb begin
		conv_cnt_next = conv_cnt_reg;
		conv_next     = conv_reg;
		shift_next    = shift_reg;
		dout_next     = dout_reg;
		if (por_reg) begin
			conv_cnt_next = 16'h0000;
			conv_next     = 1'b0;
			shift_next    = RESULT_RESET;
			dout_next     = 1'b0;
		end else begin
			// a start edge is only honoured at full power, and needs no sck [R01]
			if (cnv_fall && !conv_reg && power_reg == PWR_ON) begin
				conv_next     = 1'b1;
				conv_cnt_next = 16'h0000;
			end else if (conv_reg) begin
				if (conv_cnt_reg == 16'(CONV_CYCLES - 1)) begin
					conv_next  = 1'b0;
					// old word shifts on until the new one lands [R20]
					shift_next = sample_data_i;
					dout_next  = sample_data_i[RESULT_BITS-1];
				end else begin
					conv_cnt_next = conv_cnt_reg + 16'h0001; // [R20]
				end
			end
			if (sck_fall && !(conv_reg && conv_cnt_reg == 16'(CONV_CYCLES - 1))) begin
				// msb went out at end of conversion; each falling edge moves on, except one in the last conversion cycle [R03]
				shift_next = {shift_reg[RESULT_BITS-2:0], 1'b0};
				dout_next  = shift_reg[RESULT_BITS-2];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			conv_cnt_reg <= 16'h0000;
			conv_reg     <= 1'b0;
			shift_reg    <= RESULT_RESET;
			dout_reg     <= 1'b0;
		end else begin
			conv_cnt_reg <= conv_cnt_next;
			conv_reg     <= conv_next;
			shift_reg    <= shift_next;
			dout_reg     <= dout_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// pulse counting power modes; the standard only acts in lvds sleep, where sck neither clears the count nor wakes [R16]
	logic [2:0] pulse_cnt_reg;
	logic [2:0] pulse_cnt_next;

	always_comb begin
		power_next     = power_reg;
		pulse_cnt_next = pulse_cnt_reg;
		if (por_reg) begin
			power_next     = PWR_ON;
			pulse_cnt_next = 3'h0;
		end else if (sck_rise || sck_fall) begin
			// shift clock activity clears the count so the part stays up [R12];
			// lvds sleep keeps it, as only the fifth start pulse wakes there [R11]
			if (!(power_reg == PWR_SLEEP && sel_sync)) begin
				pulse_cnt_next = 3'h0;
			end
			if (sck_rise) begin
				case (power_reg)
					PWR_NAP:   power_next = PWR_ON; // [R07]
					// only cmos wakes from sleep on a clock edge [R09]
					PWR_SLEEP: power_next = sel_sync ? PWR_SLEEP : PWR_ON;
					default:   power_next = power_reg;
				endcase
			end
		end else if (cnv_rise) begin
			// count on the rising end of each start pulse unless a shift clock edge falls in the same cycle [R06] [R13]
			pulse_cnt_next = pulse_cnt_reg + 3'h1;
			if (pulse_cnt_reg + 3'h1 == PULSES_TO_NAP) begin
				power_next = PWR_NAP; // [R06]
			end else if (pulse_cnt_reg + 3'h1 == PULSES_TO_SLEEP) begin
				power_next = PWR_SLEEP; // [R08]
			end else if (pulse_cnt_reg + 3'h1 == PULSES_TO_WAKE) begin
				power_next     = PWR_ON; // fifth pulse wakes in either mode [R11]
				pulse_cnt_next = 3'h0; // restart so the cycle repeats [R13]
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			power_reg     <= PWR_ON;
			pulse_cnt_reg <= 3'h0;
		end else begin
			power_reg     <= power_next;
			pulse_cnt_reg <= pulse_cnt_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs; cmos leaves the negative pin undriven [R18], lvds drives both [R19]
	link_out_s out_reg;
	link_out_s out_next;

	always_comb begin
		out_next.pos    = dout_reg;
		out_next.neg    = sel_sync ? ~dout_reg : 1'b0;
		out_next.oe_pos = ~por_reg;
		out_next.oe_neg = sel_sync & ~por_reg;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			out_reg       <= '0;
			converting_o  <= 1'b0;
			power_state_o <= PWR_ON;
			por_active_o  <= 1'b1;
		end else begin
			out_reg       <= out_next;
			converting_o  <= conv_reg;
			power_state_o <= power_reg;
			por_active_o  <= por_reg;
		end
	end

	assign serial_out_o = out_reg;
endmodule
`default_nettype wire

/* host_link_model.sv */
// host side of the link: start pulses and the shift clock
// assumes the bench calls one task at a time, right after a clock edge
`default_nettype none
module host_link_model (
	// clock and mode
	input  wire logic mclk_i,
	input  wire logic lvds_i,
	// link pins
	output logic      conv_n_o,
	output logic      sck_pos_o,
	output logic      sck_neg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sck;
	initial begin
		conv_n_o = 1'b1;
		sck = 1'b0;
	end
	assign sck_pos_o = sck;
	// cmos drives the negative pin low
	assign sck_neg_o = lvds_i ? !sck : 1'b0;
	////////////////////////////////////////
	// six cycles low is well over the minimum pulse width
	task automatic pulse();
		@(posedge mclk_i) conv_n_o <= 1'b0;
		repeat (6) @(posedge mclk_i);
		conv_n_o <= 1'b1;
		repeat (14) @(posedge mclk_i);
	endtask
	// one 160 ns period; the clock stands still between calls
	task automatic sck_cycle();
		@(posedge mclk_i) sck <= 1'b1; // slowed, the block samples this clock
		repeat (10) @(posedge mclk_i);
		sck <= 1'b0;
		repeat (10) @(posedge mclk_i);
	endtask
endmodule
`default_nettype wire

/* sar_adc_serial_power_control_sva.sv */
// port assertions for the converter control block
// assumes the bench holds sample data steady during conversions
`default_nettype none
module sar_ctrl_sva (
	// clock and reset
	input wire logic                                mclk_i,
	input wire logic                                sys_rst_i,
	// watched ports
	input wire logic                                conversion_start_n_i,
	input wire logic                                shift_clock_pos_i,
	input wire logic                                io_standard_lvds_i,
	input wire logic [sar_ctrl_pkg::RESULT_BITS-1:0] sample_data_i,
	input wire sar_ctrl_pkg::link_out_s              serial_out_o,
	input wire logic                                converting_o,
	input wire sar_ctrl_pkg::power_e                 power_state_o,
	input wire logic                                por_active_o
);
	import sar_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////
	// a power-on reset may legally cut a conversion short
	a_conv_timed: assert property (disable iff (sys_rst_i || por_active_o)
		$rose(converting_o) |-> converting_o[*8] ##[28:32] !converting_o)
		else $error("conversion length off");
	a_start_taken: assert property ($fell(conversion_start_n_i) && power_state_o == PWR_ON
		&& !converting_o && !por_active_o |-> ##[3:6] converting_o)
		else $error("start edge not taken");
	a_power_order: assert property ($changed(power_state_o) && power_state_o != PWR_ON
		|-> $past(power_state_o) == (power_state_o == PWR_NAP ? PWR_ON : PWR_NAP))
		else $error("power state order");
	a_nap_wake: assert property (power_state_o == PWR_NAP && $rose(shift_clock_pos_i)
		|-> ##[1:6] power_state_o == PWR_ON)
		else $error("nap not left on clock");
	a_cmos_wake: assert property (power_state_o == PWR_SLEEP && !io_standard_lvds_i
		&& $rose(shift_clock_pos_i) |-> ##[1:6] power_state_o == PWR_ON)
		else $error("sleep not left on clock");
	a_lvds_pair: assert property (serial_out_o.oe_neg
		|-> serial_out_o.neg != serial_out_o.pos)
		else $error("pair not complementary");
	a_cmos_single: assert property (!io_standard_lvds_i[*6] |-> !serial_out_o.oe_neg
		&& !serial_out_o.neg)
		else $error("negative pin active");
	a_msb_first: assert property (disable iff (sys_rst_i || por_active_o)
		$fell(converting_o) |-> ##[0:2] serial_out_o.pos == sample_data_i[RESULT_BITS-1])
		else $error("msb not first");
endmodule
`default_nettype wire

/* sar_adc_serial_power_control_test.sv */
// bench for the converter control block with a host model on the link
// assumes the package, block, checker and host model are compiled first
`default_nettype none
module sar_adc_serial_power_control_test;
	import sar_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk;
	logic        rst;
	logic        supply_low;
	logic        lvds;
	logic        conv_n;
	logic        sck_pos;
	logic        sck_neg;
	logic [12:0] sample;
	link_out_s   sout;
	logic        converting;
	power_e      power;
	logic        por;
	int          num_errors;
	int          checks_done;
	int          cycles;
	sar_adc_serial_power_control i_sar_adc_serial_power_control (.mclk_i(mclk), .sys_rst_i(rst),
		.supply_low_i(supply_low), .conversion_start_n_i(conv_n), .shift_clock_pos_i(sck_pos),
		.shift_clock_neg_i(sck_neg), .io_standard_lvds_i(lvds), .sample_data_i(sample),
		.serial_out_o(sout), .converting_o(converting), .power_state_o(power), .por_active_o(por));
	host_link_model i_host_link_model (.mclk_i(mclk), .lvds_i(lvds), .conv_n_o(conv_n),
		.sck_pos_o(sck_pos), .sck_neg_o(sck_neg));
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			finish_test();
		end
	end
	////////////////////////////////////////
	task automatic check(input logic [12:0] got, input logic [12:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// mode pins pass a synchroniser, so let them settle before traffic
	task automatic set_std(input logic std);
		@(posedge mclk) lvds <= std;
		repeat (8) @(posedge mclk);
	endtask
	task automatic t_convert(input logic [12:0] word, input logic std);
		@(posedge mclk) sample <= word;
		set_std(std);
		i_host_link_model.pulse();
		check(13'(converting), 13'h0001);
		repeat (30) @(posedge mclk);
		check(13'(converting), 13'h0000);
		check(13'(sout.oe_neg), 13'(std));
		for (int i = 12; i >= 0; i--) begin
			check(13'(sout.pos), 13'(word[i]));
			check(13'(sout.neg), 13'(std & !word[i]));
			i_host_link_model.sck_cycle();
		end
	endtask
	task automatic t_power(input logic std);
		set_std(std);
		i_host_link_model.sck_cycle();
		i_host_link_model.pulse();
		i_host_link_model.sck_cycle();
		i_host_link_model.pulse();
		check(13'(power), 13'(PWR_ON));
		i_host_link_model.sck_cycle();
		repeat (2) i_host_link_model.pulse();
		check(13'(power), 13'(PWR_NAP));
		repeat (2) i_host_link_model.pulse();
		check(13'(power), 13'(PWR_SLEEP));
		i_host_link_model.pulse();
		check(13'(power), 13'(PWR_ON));
		repeat (2) i_host_link_model.pulse(); // results unused after sleep exit
		i_host_link_model.sck_cycle();
		check(13'(power), 13'(PWR_ON));
		repeat (4) i_host_link_model.pulse();
		i_host_link_model.sck_cycle();
		if (std) begin
			check(13'(power), 13'(PWR_SLEEP));
			i_host_link_model.pulse();
		end
		check(13'(power), 13'(PWR_ON));
	endtask
	// power-on reset taken from nap must bring the part back to full power
	task automatic t_por();
		repeat (2) i_host_link_model.pulse();
		@(posedge mclk) supply_low <= 1'b1;
		repeat (6) @(posedge mclk);
		check(13'(por), 13'h0001);
		check(13'(sout.oe_pos), 13'h0000);
		supply_low <= 1'b0;
		repeat (20) @(posedge mclk);
		check(13'(por), 13'h0000);
		check(13'(power), 13'(PWR_ON));
	endtask
	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		supply_low = 1'b0;
		lvds = 1'b0;
		sample = 13'h0000;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		check(13'(por), 13'h0001);
		check(13'(power), 13'(PWR_ON));
		repeat (18) @(posedge mclk);
		check(13'(por), 13'h0000); // first start only once reset is over
		t_convert(13'h1a5b, 1'b0);
		t_convert(13'h05a4, 1'b1);
		t_power(1'b0);
		t_power(1'b1);
		t_por();
		finish_test();
	end
endmodule
bind sar_adc_serial_power_control sar_ctrl_sva i_sar_ctrl_sva (.mclk_i, .sys_rst_i,
	.conversion_start_n_i, .shift_clock_pos_i, .io_standard_lvds_i, .sample_data_i,
	.serial_out_o, .converting_o, .power_state_o, .por_active_o);
`default_nettype wire
